// ===== hw/tsc_defs.svh
// Offsets, field positions, reset values and counts of the TDM port
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_ADDR_CTRL    5'h00
`define TSC_ADDR_MCR_RX  5'h04
`define TSC_ADDR_MCR_TX  5'h08
`define TSC_ADDR_RX_CER  5'h0c
`define TSC_ADDR_TX_CER  5'h10
`define TSC_ADDR_RX_DATA 5'h14
`define TSC_ADDR_TX_DATA 5'h18
`define TSC_ADDR_STATUS  5'h1c
`define TSC_CTRL_RESET   22'h000000
`define TSC_CTRL_WIDTH   22
`define TSC_MCR_RESET    16'h0000
`define TSC_MCR_WMASK_RX 16'h01e1
`define TSC_MCR_WMASK_TX 16'h01e3
`define TSC_CER_RESET    32'h00000000
`define TSC_DIV_MSB      7
`define TSC_SRC_POL      8
`define TSC_GEN_SYNC_ENABLE        9
`define TSC_FS_MODE      10
`define TSC_FS_POL       11
`define TSC_DLY_MSB      13
`define TSC_DLY_LSB      12
`define TSC_FRLEN_MSB    20
`define TSC_FRLEN_LSB    14
`define TSC_DUAL_PHASE   21
`define TSC_PB_MSB       8
`define TSC_PB_LSB       7
`define TSC_PA_MSB       6
`define TSC_PA_LSB       5
`define TSC_MC_MSB       1
`define TSC_MC_LSB       0
`define TSC_LAST_BIT     3'h7
`define TSC_RESP_OKAY    2'h0
`define TSC_RESP_SLVERR  2'h2
`endif

// ===== hw/tsc_pkg.sv
// Types shared by the TDM channel select port
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_IDLE,
    TSC_DELAY,
    TSC_DATA
  } tsc_state_t;
endpackage

// ===== hw/tsc_channel_select.sv
// TDM serial port: clock generation, framing and channel selection
//
// Summary of operation
// - Divide field zero runs bit clocks straight from source clock.
// - Polarity zero takes source clock rising edge as active edge.
// - Frame sync sampled on rising source edge resynchronises bit clocks.
// - Internal frame sync held until next falling bit clock edge.
// - Divide field one gives bit clocks at half source rate.
// - Sync enable zero lets generated clock run free.
// - Frame sync polarity zero treats input as active high.
// - Data delay one starts first bit one bit clock after sync.
// - Selection only in single phase; channels equal words per frame.
// - At most 32 of 128 channels enabled at once.
// - Disabled receive channel neither copies data nor sets ready.
// - Disabled receive word raises no event to CPU or DMA.
// - Disabled transmit channel leaves data pin high impedance.
// - Disabled transmit word triggers no data to shift copy.
// - Disabled transmit word leaves empty and ready flags alone.
// - Masked enabled channel floats pin; unmasked drives data.
// - Receive partition B field picks odd block 1,3,5,7.
// - Receive partition A field picks even block 0,2,4,6.
// - Read-only current block field shows block being received.
// - Receive enable bit zero enables all; one enables selected only.
// - Both control registers reset zero; reserved and current read-only.
// - Transmit mode: all, selected, all-masked, receive-selected masked.
// - Eight blocks of sixteen; even in A, odd in B.
// - Pin floats between frames, in masked and disabled channels.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_channel_select (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [4:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [4:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_external_source_clock,
  input  wire logic        i_receive_frame_sync,
  input  wire logic        i_serial_data_in,
  output logic             o_serial_data_out_pin,
  output logic             o_serial_data_out_oe_n,
  output logic             o_receive_bit_clock,
  output logic             o_transmit_bit_clock,
  output logic             o_internal_frame_sync,
  output logic             o_receive_ready_flag,
  output logic             o_transmit_ready_flag
);

  // Channel select within chosen A and B blocks
  function automatic logic chan_sel(
    input logic [6:0]  idx,
    input logic [1:0]  pa,
    input logic [1:0]  pb,
    input logic [31:0] cer
  );
    logic r;
    r = 1'b0;
    if (idx[6:4] == {pa, 1'b0}) begin
      r = cer[{1'b0, idx[3:0]}];
    end else if (idx[6:4] == {pb, 1'b1}) begin
      r = cer[{1'b1, idx[3:0]}];
    end
    return r;
  endfunction

  function automatic logic [31:0] strb_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [`TSC_CTRL_WIDTH-1:0] ctrl_reg;
  logic [15:0]       mcr_rx_reg;
  logic [15:0]       mcr_tx_reg;
  logic [31:0]       rx_cer_reg;
  logic [31:0]       tx_cer_reg;
  logic [7:0]        rx_data_reg;
  logic [7:0]        tx_data_reg;
  logic              rx_ready_reg;
  logic              tx_ready_reg;
  logic              tx_empty_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [4:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [2:0]        pin_lvl;
  logic              src_prev_reg;
  logic              fs_smp_reg;
  logic [7:0]        div_cnt_reg;
  logic              gen_clk_reg;
  logic              fs_hold_reg;
  tsc_pkg::tsc_state_t state_reg;
  logic [1:0]        dly_reg;
  logic [2:0]        bit_reg;
  logic [6:0]        idx_reg;
  logic              rx_en_reg;
  logic              tx_en_reg;
  logic              tx_drv_reg;
  logic [7:0]        rx_shift_reg;
  logic [7:0]        tx_shift_reg;

  wire [7:0] div      = ctrl_reg[`TSC_DIV_MSB:0];
  wire       src_pol  = ctrl_reg[`TSC_SRC_POL];
  wire       gen_sync_enable    = ctrl_reg[`TSC_GEN_SYNC_ENABLE];
  wire       fs_mode  = ctrl_reg[`TSC_FS_MODE];
  wire       fs_pol   = ctrl_reg[`TSC_FS_POL];
  wire [1:0] data_dly = ctrl_reg[`TSC_DLY_MSB:`TSC_DLY_LSB];
  wire [6:0] frlen    = ctrl_reg[`TSC_FRLEN_MSB:`TSC_FRLEN_LSB];
  wire       mc_ok    = ~ctrl_reg[`TSC_DUAL_PHASE];
  wire [1:0] rx_pb    = mcr_rx_reg[`TSC_PB_MSB:`TSC_PB_LSB];
  wire [1:0] rx_pa    = mcr_rx_reg[`TSC_PA_MSB:`TSC_PA_LSB];
  wire       rx_mcm   = mcr_rx_reg[`TSC_MC_LSB];
  wire [1:0] tx_pb    = mcr_tx_reg[`TSC_PB_MSB:`TSC_PB_LSB];
  wire [1:0] tx_pa    = mcr_tx_reg[`TSC_PA_MSB:`TSC_PA_LSB];
  wire [1:0] tx_mcm   = mcr_tx_reg[`TSC_MC_MSB:`TSC_MC_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  wire [2:0] pins = {i_serial_data_in, i_receive_frame_sync,
                     i_external_source_clock};
  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    logic [2:0] s_reg;
    logic       lvl_reg;
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        s_reg   <= 3'h0;
        lvl_reg <= 1'b0;
      end else begin
        s_reg <= {s_reg[1:0], pins[g]};
        if (s_reg[1] == s_reg[2]) begin
          lvl_reg <= s_reg[2];
        end
      end
    end
    assign pin_lvl[g] = lvl_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Source clock edges and generated bit clock
  wire src_chg  = pin_lvl[0] ^ src_prev_reg;
  wire act_edge = src_chg & (pin_lvl[0] ^ src_pol);
  wire opp_edge = src_chg & ~(pin_lvl[0] ^ src_pol);
  wire fs_now   = pin_lvl[1] ^ fs_pol;
  wire fs_evt   = act_edge & fs_now & ~fs_smp_reg;
  wire resync   = gen_sync_enable & fs_evt;
  wire rise_tick = act_edge & (resync | (div_cnt_reg == div));
  // Single rate uses the opposite source edge for the low phase
  wire fall_tick = (div == 8'h00) ? opp_edge
                 : act_edge & ~rise_tick
                   & (div_cnt_reg == (div >> 1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      src_prev_reg <= 1'b0;
      fs_smp_reg   <= 1'b0;
    end else begin
      src_prev_reg <= pin_lvl[0];
      if (act_edge) begin
        fs_smp_reg <= fs_now;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      div_cnt_reg <= 8'h00;
      gen_clk_reg <= 1'b0;
    end else begin
      if (act_edge) begin
        div_cnt_reg <= rise_tick ? 8'h00 : div_cnt_reg + 8'h01;
      end
      if (rise_tick) begin
        gen_clk_reg <= 1'b1;
      end else if (fall_tick) begin
        gen_clk_reg <= 1'b0;
      end
    end
  end

  // Held so the frame start is seen at the next falling bit edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fs_hold_reg <= 1'b0;
    end else if (fs_evt & (~fs_mode | gen_sync_enable)) begin
      fs_hold_reg <= 1'b1;
    end else if (fall_tick) begin
      fs_hold_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Framing: delay, bit and channel counters
  wire in_delay  = (state_reg == tsc_pkg::TSC_DELAY);
  wire in_data   = (state_reg == tsc_pkg::TSC_DATA);
  wire last_bit  = (bit_reg == `TSC_LAST_BIT);
  wire start_word = rise_tick
                  & ((in_delay & (dly_reg == 2'h0))
                  | (in_data & last_bit & (idx_reg != frlen)));
  wire [6:0] next_idx = in_delay ? 7'h00 : idx_reg + 7'h01;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= tsc_pkg::TSC_IDLE;
      dly_reg   <= 2'h0;
      bit_reg   <= 3'h0;
      idx_reg   <= 7'h00;
    end else if (fall_tick & fs_hold_reg) begin
      state_reg <= tsc_pkg::TSC_DELAY;
      dly_reg   <= data_dly;
    end else if (rise_tick) begin
      if (start_word) begin
        state_reg <= tsc_pkg::TSC_DATA;
        bit_reg   <= 3'h0;
        idx_reg   <= next_idx;
      end else begin
        case (state_reg)
          tsc_pkg::TSC_DELAY: begin
            dly_reg <= dly_reg - 2'h1;
          end
          tsc_pkg::TSC_DATA: begin
            if (last_bit) begin
              state_reg <= tsc_pkg::TSC_IDLE;
            end else begin
              bit_reg <= bit_reg + 3'h1;
            end
          end
          default: begin
            state_reg <= tsc_pkg::TSC_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel enable and mask, fixed at the start of each word
  logic rx_en_next;
  logic tx_en_next;
  logic tx_drv_next;
  always_comb begin
    rx_en_next  = ~(mc_ok & rx_mcm)
                | chan_sel(next_idx, rx_pa, rx_pb, rx_cer_reg);
    tx_en_next  = 1'b1;
    tx_drv_next = 1'b1;
    if (mc_ok) begin
      case (tx_mcm)
        2'h1: begin
          tx_en_next  = chan_sel(next_idx, tx_pa, tx_pb, tx_cer_reg);
          tx_drv_next = tx_en_next;
        end
        2'h2: begin
          tx_drv_next = chan_sel(next_idx, tx_pa, tx_pb, tx_cer_reg);
        end
        2'h3: begin
          tx_en_next  = chan_sel(next_idx, rx_pa, rx_pb, rx_cer_reg);
          tx_drv_next = tx_en_next
                      & chan_sel(next_idx, rx_pa, rx_pb, tx_cer_reg);
        end
        default: begin
          tx_en_next  = 1'b1;
          tx_drv_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_en_reg  <= 1'b0;
      tx_en_reg  <= 1'b0;
      tx_drv_reg <= 1'b0;
    end else if (start_word) begin
      rx_en_reg  <= rx_en_next;
      tx_en_reg  <= tx_en_next;
      tx_drv_reg <= tx_drv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift paths: launch on rising, sample on falling bit edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tx_shift_reg <= 8'h00;
    end else if (start_word) begin
      if (tx_en_next & ~tx_ready_reg) begin
        tx_shift_reg <= tx_data_reg;
      end
    end else if (rise_tick & in_data) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_shift_reg <= 8'h00;
      rx_data_reg  <= 8'h00;
    end else if (fall_tick & in_data) begin
      rx_shift_reg <= {rx_shift_reg[6:0], pin_lvl[2]};
      if (last_bit & rx_en_reg) begin
        rx_data_reg <= {rx_shift_reg[6:0], pin_lvl[2]};
      end
    end
  end

  // A hardware set wins over a software clear in the same cycle
  wire rd_rx_data = i_s_axi_arvalid & ~rvalid_reg
                  & (i_s_axi_araddr == `TSC_ADDR_RX_DATA);
  wire do_write   = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wr_tx_data = do_write & (aw_addr_reg == `TSC_ADDR_TX_DATA);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_ready_reg <= 1'b0;
      tx_ready_reg <= 1'b1;
      tx_empty_reg <= 1'b1;
    end else begin
      if (rd_rx_data) begin
        rx_ready_reg <= 1'b0;
      end
      if (fall_tick & in_data & last_bit & rx_en_reg) begin
        rx_ready_reg <= 1'b1;
      end
      if (wr_tx_data) begin
        tx_ready_reg <= 1'b0;
      end
      if (start_word & tx_en_next) begin
        tx_empty_reg <= tx_ready_reg;
        tx_ready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus, write side: address and data taken in either order
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TSC_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid & ~aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid & ~w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (aw_addr_reg > `TSC_ADDR_STATUS)
                     ? `TSC_RESP_SLVERR : `TSC_RESP_OKAY;
      end else if (bvalid_reg & i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  wire [31:0] wr_word = strb_merge(32'h00000000, w_data_reg, w_strb_reg);
  wire [31:0] wr_mask = strb_merge(32'h00000000, 32'hffffffff, w_strb_reg);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_reg    <= `TSC_CTRL_RESET;
      mcr_rx_reg  <= `TSC_MCR_RESET;
      mcr_tx_reg  <= `TSC_MCR_RESET;
      rx_cer_reg  <= `TSC_CER_RESET;
      tx_cer_reg  <= `TSC_CER_RESET;
      tx_data_reg <= 8'h00;
    end else if (do_write) begin
      case (aw_addr_reg)
        `TSC_ADDR_CTRL: begin
          ctrl_reg <= (ctrl_reg & ~wr_mask[`TSC_CTRL_WIDTH-1:0])
                    | wr_word[`TSC_CTRL_WIDTH-1:0];
        end
        `TSC_ADDR_MCR_RX: begin
          mcr_rx_reg <= (mcr_rx_reg & ~(wr_mask[15:0] & `TSC_MCR_WMASK_RX))
                      | (wr_word[15:0] & `TSC_MCR_WMASK_RX);
        end
        `TSC_ADDR_MCR_TX: begin
          mcr_tx_reg <= (mcr_tx_reg & ~(wr_mask[15:0] & `TSC_MCR_WMASK_TX))
                      | (wr_word[15:0] & `TSC_MCR_WMASK_TX);
        end
        `TSC_ADDR_RX_CER: begin
          rx_cer_reg <= strb_merge(rx_cer_reg, w_data_reg, w_strb_reg);
        end
        `TSC_ADDR_TX_CER: begin
          tx_cer_reg <= strb_merge(tx_cer_reg, w_data_reg, w_strb_reg);
        end
        `TSC_ADDR_TX_DATA: begin
          if (w_strb_reg[0]) begin
            tx_data_reg <= w_data_reg[7:0];
          end
        end
        default: begin
          tx_data_reg <= tx_data_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus, read side
  wire [2:0] cur_blk = idx_reg[6:4];
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `TSC_RESP_OKAY;
    end else if (i_s_axi_arvalid & ~rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `TSC_RESP_OKAY;
      case (i_s_axi_araddr)
        `TSC_ADDR_CTRL:    rdata_reg <= {10'h000, ctrl_reg};
        `TSC_ADDR_MCR_RX:  rdata_reg <= {16'h0000, mcr_rx_reg
                                         | {11'h000, cur_blk, 2'h0}};
        `TSC_ADDR_MCR_TX:  rdata_reg <= {16'h0000, mcr_tx_reg
                                         | {11'h000, cur_blk, 2'h0}};
        `TSC_ADDR_RX_CER:  rdata_reg <= rx_cer_reg;
        `TSC_ADDR_TX_CER:  rdata_reg <= tx_cer_reg;
        `TSC_ADDR_RX_DATA: rdata_reg <= {24'h000000, rx_data_reg};
        `TSC_ADDR_TX_DATA: rdata_reg <= {24'h000000, tx_data_reg};
        `TSC_ADDR_STATUS:  rdata_reg <= {29'h00000000, tx_empty_reg,
                                         tx_ready_reg, rx_ready_reg};
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `TSC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg & i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_s_axi_awready = ~aw_full_reg;
  assign o_s_axi_wready  = ~w_full_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = ~rvalid_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;

  // Shared bus: float outside frames and in disabled or masked slots
  assign o_serial_data_out_pin  = tx_shift_reg[7];
  assign o_serial_data_out_oe_n = ~(in_data & tx_en_reg
                                    & tx_drv_reg);
  assign o_receive_bit_clock    = gen_clk_reg;
  assign o_transmit_bit_clock   = gen_clk_reg;
  assign o_internal_frame_sync  = fs_hold_reg;
  assign o_receive_ready_flag   = rx_ready_reg;
  assign o_transmit_ready_flag  = tx_ready_reg;

endmodule

// ===== verification/tsc_channel_select_properties.sv
// Concurrent checks on the TDM channel select port
`timescale 1ns/1ps
module tsc_channel_select_properties (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic        o_serial_data_out_pin,
  input wire logic        o_serial_data_out_oe_n,
  input wire logic        o_receive_bit_clock,
  input wire logic        o_transmit_bit_clock,
  input wire logic        o_internal_frame_sync,
  input wire logic        o_receive_ready_flag,
  input wire logic        o_transmit_ready_flag
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_reset_idle_state: assert property (disable iff (1'b0)
    i_reset |=> o_serial_data_out_oe_n && !o_s_axi_bvalid
      && !o_s_axi_rvalid && !o_receive_ready_flag && o_transmit_ready_flag)
    else $error("outputs not idle after reset");
  a_bit_clock_toggles: assert property (
    $rose(o_receive_bit_clock) |-> ##[1:17] $fell(o_receive_bit_clock))
    else $error("bit clock stuck high");
  a_rx_ready_fall: assert property (
    $rose(o_receive_ready_flag) |-> !o_receive_bit_clock)
    else $error("rx ready set outside a falling tick");
  a_tx_copy_rise: assert property (
    $rose(o_transmit_ready_flag) |-> o_transmit_bit_clock)
    else $error("tx ready set outside a rising tick");
  a_pin_launch_edge: assert property (
    $changed(o_serial_data_out_pin) |-> $rose(o_transmit_bit_clock))
    else $error("data pin changed off the rising tick");
  a_sync_stretch_end: assert property (
    $fell(o_internal_frame_sync) |-> !o_receive_bit_clock)
    else $error("frame sync dropped before falling tick");
  a_drive_word_start: assert property (
    $fell(o_serial_data_out_oe_n) |-> $rose(o_transmit_bit_clock))
    else $error("pin driven off a word boundary");
  a_bresp_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");
  c_rx_ready: cover property ($rose(o_receive_ready_flag));
  c_tx_ready: cover property ($rose(o_transmit_ready_flag));
  c_pin_drive: cover property ($fell(o_serial_data_out_oe_n));
endmodule

bind tsc_channel_select tsc_channel_select_properties u_props (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .o_serial_data_out_pin(o_serial_data_out_pin),
  .o_serial_data_out_oe_n(o_serial_data_out_oe_n),
  .o_receive_bit_clock(o_receive_bit_clock),
  .o_transmit_bit_clock(o_transmit_bit_clock),
  .o_internal_frame_sync(o_internal_frame_sync),
  .o_receive_ready_flag(o_receive_ready_flag),
  .o_transmit_ready_flag(o_transmit_ready_flag));

// ===== verification/tsc_far_end.sv
// Far-end TDM device: source clock, frame sync and serial data
`timescale 1ns/1ps
module tsc_far_end #(
  parameter int HALF_NS   = 400,
  parameter int FRAME_SRC = 600
) (
  output logic o_src_clk,
  output logic o_frame_sync,
  output logic o_data
);
  int src_cnt = 0;
  // Odd offset keeps source edges clear of system clock edges
  initial begin
    o_src_clk = 1'b0;
    #37;
    forever #HALF_NS o_src_clk = ~o_src_clk;
  end
  // Pulse one source period wide, active high, set up before rising edge
  always @(negedge o_src_clk) begin
    src_cnt <= (src_cnt == FRAME_SRC - 1) ? 0 : src_cnt + 1;
    o_frame_sync <= (src_cnt == 0);
    o_data <= 1'($urandom);
  end
  initial o_frame_sync = 1'b0;
  initial o_data = 1'b1;
endmodule

// ===== verification/tb_tdm_serial_channel_select.sv
// Self-checking bench for the TDM channel select port
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tb_tdm_serial_channel_select;
  localparam int NW = 34;
  localparam int FCYC = 4800;
  logic        clk = 1'b0, rst = 1'b1;
  logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        src, fsync, sdin, sdout, oe_n, rbclk, tbclk, ifs, receive_ready_flag, trdy;
  logic        prev_b = 1'b0;
  int          n_fail = 0, total_checks = 0;
  int          oe_cnt = 0, bper = 0, last_rise = 0, cyc = 0;
  tsc_far_end far_u (.o_src_clk(src), .o_frame_sync(fsync), .o_data(sdin));
  tsc_channel_select dut_u (
    .i_sys_clk(clk), .i_reset(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_external_source_clock(src),
    .i_receive_frame_sync(fsync), .i_serial_data_in(sdin),
    .o_serial_data_out_pin(sdout), .o_serial_data_out_oe_n(oe_n),
    .o_receive_bit_clock(rbclk), .o_transmit_bit_clock(tbclk),
    .o_internal_frame_sync(ifs), .o_receive_ready_flag(receive_ready_flag),
    .o_transmit_ready_flag(trdy));
////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  // Free-running counters; main sequence only takes differences
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_b <= rbclk;
    if (rbclk === 1'b1 && prev_b === 1'b0) begin
      bper <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (oe_n === 1'b0) oe_cnt <= oe_cnt + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    // Late bready lets the response wait on the master
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  function automatic bit sel(int ch, logic [1:0] pa, logic [1:0] pb,
                             logic [31:0] cer);
    if (ch / 16 == 2 * pa) return cer[ch % 16];
    if (ch / 16 == 2 * pb + 1) return cer[16 + ch % 16];
    return 1'b0;
  endfunction
  function automatic void expect_cfg(input logic [31:0] mr, mt, rc, tc,
                                     output int drv, output bit ten, ren);
    bit e, d;
    drv = 0;
    ten = 1'b0;
    ren = 1'b0;
    for (int ch = 0; ch < NW; ch++) begin
      ren |= (mr[0] == 1'b0) || sel(ch, mr[6:5], mr[8:7], rc);
      case (mt[1:0])
        2'h0: begin e = 1'b1; d = 1'b1; end
        2'h1: begin e = sel(ch, mt[6:5], mt[8:7], tc); d = e; end
        2'h2: begin e = 1'b1; d = sel(ch, mt[6:5], mt[8:7], tc); end
        default: begin
          e = sel(ch, mr[6:5], mr[8:7], rc);
          d = e && sel(ch, mr[6:5], mr[8:7], tc);
        end
      endcase
      drv += d;
      ten |= e;
    end
  endfunction
  initial begin
    #(100 * 90000);
    n_fail++;
    end_sim();
  end
  initial begin
    logic [31:0] rv, mr, mt, rc, tc, ctrl;
    logic [1:0]  rs;
    logic [4:0]  adr [2];
    logic [31:0] wm [2];
    int          drv, c0, bp;
    bit          ten, ren;
    adr = '{`TSC_ADDR_MCR_RX, `TSC_ADDR_MCR_TX};
    wm = '{32'h1e1, 32'h1e3};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    void'($urandom(32'h4bd8));
    for (int k = 0; k < 2; k++) begin
      rd(adr[k], rv, rs);
      chk("control reset value", 32'h0, rv);
      wr(adr[k], 32'hffffffff, rs);
      rd(adr[k], rv, rs);
      chk("control writable bits", wm[k], rv);
    end
    rd(5'h1f, rv, rs);
    chk("unmapped read response", 32'h2, 32'(rs));
    // Frame of 34 words spans blocks 0 to 2, delay of one bit
    for (int i = 0; i < 6; i++) begin
      mr = (i == 0) ? 32'h0 : {23'h0, 4'($urandom), 4'h0, 1'b1};
      mt = (i == 0) ? 32'h0 : {23'h0, 4'($urandom), 3'h0, 2'(i)};
      rc = (i == 5) ? 32'h0 : $urandom;
      tc = (i == 5) ? 32'h0 : $urandom;
      ctrl = {11'h0, 7'h21, 2'h1, 2'h0, i == 3, 1'b0, 8'(i / 3)};
      wr(`TSC_ADDR_CTRL, ctrl, rs);
      wr(`TSC_ADDR_MCR_RX, mr, rs);
      wr(`TSC_ADDR_MCR_TX, mt, rs);
      wr(`TSC_ADDR_RX_CER, rc, rs);
      wr(`TSC_ADDR_TX_CER, tc, rs);
      repeat (FCYC) @(posedge clk);
      rd(`TSC_ADDR_RX_DATA, rv, rs);
      wr(`TSC_ADDR_TX_DATA, $urandom, rs);
      c0 = oe_cnt;
      repeat (FCYC) @(posedge clk);
      expect_cfg(mr, mt, rc, tc, drv, ten, ren);
      bp = 8 * (i / 3 + 1);
      chk("bit clock period", bp, bper);
      chk("driven channels", drv, (oe_cnt - c0 + 4 * bp) / (8 * bp));
      rd(`TSC_ADDR_STATUS, rv, rs);
      chk("rx ready", 32'(ren), 32'(rv[0]));
      chk("tx ready", 32'(ten), 32'(rv[1]));
    end
    end_sim();
  end
endmodule
